// File: inc/pin_mux_pkg.sv
// Purpose: Shared constants and carriers for the low port pin function select block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Register values are 16 bits wide and sit in the low half of the word.
package pin_mux_pkg;

  localparam logic [11:0] sel1_offset     = 12'h000;
  localparam logic [11:0] sel2_offset     = 12'h004;
  localparam logic [15:0] sel1_mask       = 16'h555F;
  localparam logic [15:0] sel2_mask       = 16'hFD75;
  localparam logic [15:0] sel1_reset_ext  = 16'h4000;
  localparam logic [15:0] sel1_reset_chip = 16'h0000;
  localparam logic [15:0] sel2_reset      = 16'h0000;

  localparam int pin15_bit = 14;
  localparam int pin14_bit = 12;
  localparam int pin13_bit = 10;
  localparam int pin12_bit = 8;
  localparam int pin11_bit = 6;
  localparam int pin10_bit = 4;
  localparam int pin9_lsb  = 2;
  localparam int pin8_lsb  = 0;
  localparam int pin7_lsb  = 14;
  localparam int pin6_lsb  = 12;
  localparam int pin5_lsb  = 10;
  localparam int pin4_bit  = 8;
  localparam int pin3_bit  = 6;
  localparam int pin2_lsb  = 4;
  localparam int pin1_bit  = 2;
  localparam int pin0_bit  = 0;

  localparam logic [1:0] code_gpio = 2'h0;
  localparam logic [1:0] code_alt1 = 2'h1;
  localparam logic [1:0] code_alt2 = 2'h2;
  localparam logic [1:0] code_alt3 = 2'h3;

  // Outputs of the internal peripherals that may reach the pins.
  typedef struct packed {
    logic system_clk_output;
    logic read_strobe_n;
    logic upper_write_strobe_n;
    logic lower_write_strobe_n;
    logic chip_select_zero_n;
    logic chip_select_one_n;
    logic chip_select_two_n;
    logic chip_select_three_n;
    logic serial_clock_ch0_out;
    logic serial_clock_ch0_oe;
    logic serial_clock_ch1_out;
    logic serial_clock_ch1_oe;
    logic serial_transmit_ch0;
    logic serial_transmit_ch1;
  } periph_out_t;

  // Pin levels handed to the internal peripherals; idle level when not selected.
  typedef struct packed {
    logic timer_ext_clock_a;
    logic timer_ext_clock_b;
    logic timer_ext_clock_c;
    logic timer_ext_clock_d;
    logic ext_interrupt_in_0;
    logic ext_interrupt_in_1;
    logic ext_interrupt_in_2;
    logic ext_interrupt_in_3;
    logic serial_clock_ch0_in;
    logic serial_clock_ch1_in;
    logic serial_receive_ch0;
    logic serial_receive_ch1;
    logic dma_request_in_0;
    logic dma_request_in_1;
  } periph_in_t;

endpackage

// File: rtl/port_a_low_pin_function_select.sv
// Purpose: Function select multiplexer for the lower sixteen pins of port A.
// Assumes: Software reaches both select registers over APB; mode straps are static levels.
// Notes:   rst is the external power-on reset only; other resets never reach this block.
//
// Summary of operation
// - Select 1 bit 14 gives pin 15 the clock; reset value follows extended mode.
// - Reserved bits read zero and ignore writes; software writes zero there.
// - Select 1 bit 12 puts the read strobe on pin 14.
// - Select 1 bit 10 puts the upper write strobe on pin 13.
// - Select 1 bit 8 puts the lower write strobe on pin 12.
// - Select 1 bit 6 puts chip select one on pin 11.
// - Select 1 bit 4 puts chip select zero on pin 10.
// - With on-chip ROM disabled in extended mode, pins 14 to 10 carry bus strobes regardless.
// - In single chip mode, bus strobe, chip select or DMA choices stay general I/O.
// - Select 1 bits 3:2 pick pin 9: I/O, timer clock D, interrupt 3.
// - Select 1 bits 1:0 pick pin 8: I/O, timer clock C, interrupt 2.
// - Select 2 bits 15:14 pick pin 7: I/O, timer clock B, chip select three.
// - Select 2 bits 13:12 pick pin 6: I/O, timer clock A, chip select two.
// - Select 2 bits 11:10 pick pin 5: I/O, serial clock 1, DMA 1, interrupt 1.
// - Select 2 bit 8 puts serial transmit 1 on pin 4.
// - Select 2 bit 6 feeds pin 3 to serial receive 1.
// - Select 2 bits 5:4 pick pin 2: I/O, serial clock 0, DMA 0, interrupt 0.
// - Select 2 bit 2 puts serial transmit 0 on pin 1.
// - Select 2 bit 0 feeds pin 0 to serial receive 0.
// - Select 2 resets to all zero, every pin general I/O.
// - Only the power-on reset loads initial values; other resets keep contents.
`timescale 1ns/1ps
`default_nettype none

module port_a_low_pin_function_select
  import pin_mux_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     extended_mode,
  input  wire logic                     rom_disabled,
  input  wire logic [15:0]              gpio_out,
  input  wire logic [15:0]              gpio_oe,
  output logic      [15:0]              gpio_in,
  input  wire pin_mux_pkg::periph_out_t periph_out,
  output pin_mux_pkg::periph_in_t       periph_in,
  input  wire logic [15:0]              pin_in,
  output logic      [15:0]              pin_out,
  output logic      [15:0]              pin_oe
);
  import pin_mux_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised pins and mode straps.

  logic [15:0] pin_meta;
  logic [15:0] pin_sync;
  logic [1:0]  mode_meta;
  logic [1:0]  mode_sync;
  logic        loaded;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_meta  <= 16'h0000;
      pin_sync  <= 16'h0000;
      mode_meta <= 2'h0;
      mode_sync <= 2'h0;
    end else begin
      pin_meta  <= pin_in;
      pin_sync  <= pin_meta;
      mode_meta <= {extended_mode, rom_disabled};
      mode_sync <= mode_meta;
    end
  end

  wire ext_mode  = mode_sync[1];
  wire rom_off   = mode_sync[0];
  wire bus_allow = ext_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Select registers.

  logic [15:0] sel1;
  logic [15:0] sel2;

  wire         wr_access = psel && penable && pwrite;
  wire         hit1      = (paddr == sel1_offset);
  wire         hit2      = (paddr == sel2_offset);
  wire  [15:0] wdata     = pwdata[15:0];

  // The strap is caught on the third edge after release, once the synchroniser has settled,
  // so the reset itself only ever loads constants.
  logic [1:0] settle;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      settle <= 2'h0;
      loaded <= 1'b0;
    end else begin
      settle <= {settle[0], 1'b1};
      if (settle[1] && !loaded) begin
        loaded <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sel1 <= sel1_reset_chip;
      sel2 <= sel2_reset;
    end else if (settle[1] && !loaded) begin
      sel1 <= ext_mode ? sel1_reset_ext : sel1_reset_chip;
    end else if (wr_access && hit1) begin
      sel1 <= wdata & sel1_mask;
    end else if (wr_access && hit2) begin
      sel2 <= wdata & sel2_mask;
    end
  end

  wire [15:0] rd_word = hit1 ? sel1 : (hit2 ? sel2 : 16'h0000);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {16'h0000, rd_word};
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(hit1 || hit2);

  ////////////////////////////////////////////////////////////////////////////
  // Function decode.

  function automatic logic bus_on(input logic sel_bit);
    bus_on = bus_allow && (sel_bit || rom_off);
  endfunction

  wire [1:0] f9 = sel1[pin9_lsb +: 2];
  wire [1:0] f8 = sel1[pin8_lsb +: 2];
  wire [1:0] f7 = sel2[pin7_lsb +: 2];
  wire [1:0] f6 = sel2[pin6_lsb +: 2];
  wire [1:0] f5 = sel2[pin5_lsb +: 2];
  wire [1:0] f2 = sel2[pin2_lsb +: 2];

  wire clk15 = sel1[pin15_bit];
  wire rd14  = bus_on(sel1[pin14_bit]);
  wire wh13  = bus_on(sel1[pin13_bit]);
  wire wl12  = bus_on(sel1[pin12_bit]);
  wire cs11  = bus_on(sel1[pin11_bit]);
  wire cs10  = bus_on(sel1[pin10_bit]);
  wire tc9   = (f9 == code_alt1);
  wire iq9   = (f9 == code_alt2);
  wire tc8   = (f8 == code_alt1);
  wire iq8   = (f8 == code_alt2);
  wire tc7   = (f7 == code_alt1);
  wire cs7   = (f7 == code_alt2) && bus_allow;
  wire tc6   = (f6 == code_alt1);
  wire cs6   = (f6 == code_alt2) && bus_allow;
  wire sc5   = (f5 == code_alt1);
  wire dq5   = (f5 == code_alt2) && bus_allow;
  wire iq5   = (f5 == code_alt3);
  wire tx4   = sel2[pin4_bit];
  wire rx3   = sel2[pin3_bit];
  wire sc2   = (f2 == code_alt1);
  wire dq2   = (f2 == code_alt2) && bus_allow;
  wire iq2   = (f2 == code_alt3);
  wire tx1   = sel2[pin1_bit];
  wire rx0   = sel2[pin0_bit];

  // Pins given to a peripheral: driven ones and input-only ones alike.
  wire [15:0] periph_sel = {clk15, rd14, wh13, wl12, cs11, cs10, tc9 | iq9, tc8 | iq8,
                            tc7 | cs7, tc6 | cs6, sc5 | dq5 | iq5, tx4, rx3,
                            sc2 | dq2 | iq2, tx1, rx0};

  wire [15:0] periph_drv = {periph_out.system_clk_output, periph_out.read_strobe_n,
                            periph_out.upper_write_strobe_n, periph_out.lower_write_strobe_n,
                            periph_out.chip_select_one_n, periph_out.chip_select_zero_n,
                            2'h0, periph_out.chip_select_three_n,
                            periph_out.chip_select_two_n, periph_out.serial_clock_ch1_out,
                            periph_out.serial_transmit_ch1, 1'b0,
                            periph_out.serial_clock_ch0_out,
                            periph_out.serial_transmit_ch0, 1'b0};

  // Input-only functions release the pin; serial clocks follow their own enable.
  wire [15:0] periph_en  = {6'h3F, 2'h0, cs7, cs6,
                            sc5 & periph_out.serial_clock_ch1_oe, 1'b1, 1'b0,
                            sc2 & periph_out.serial_clock_ch0_oe, 1'b1, 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive and peripheral inputs.

  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_pin
      assign pin_out[i] = periph_sel[i] ? periph_drv[i] : gpio_out[i];
      assign pin_oe[i]  = periph_sel[i] ? periph_en[i] : gpio_oe[i];
      assign gpio_in[i] = pin_sync[i];
    end
  endgenerate

  // Deselected interrupt, DMA and receive inputs idle high so active-low requests stay quiet; clock inputs idle low.
  assign periph_in.timer_ext_clock_a   = tc6 ? pin_sync[6] : 1'b0;
  assign periph_in.timer_ext_clock_b   = tc7 ? pin_sync[7] : 1'b0;
  assign periph_in.timer_ext_clock_c   = tc8 ? pin_sync[8] : 1'b0;
  assign periph_in.timer_ext_clock_d   = tc9 ? pin_sync[9] : 1'b0;
  assign periph_in.ext_interrupt_in_0  = iq2 ? pin_sync[2] : 1'b1;
  assign periph_in.ext_interrupt_in_1  = iq5 ? pin_sync[5] : 1'b1;
  assign periph_in.ext_interrupt_in_2  = iq8 ? pin_sync[8] : 1'b1;
  assign periph_in.ext_interrupt_in_3  = iq9 ? pin_sync[9] : 1'b1;
  assign periph_in.serial_clock_ch0_in = sc2 ? pin_sync[2] : 1'b0;
  assign periph_in.serial_clock_ch1_in = sc5 ? pin_sync[5] : 1'b0;
  assign periph_in.serial_receive_ch0  = rx0 ? pin_sync[0] : 1'b1;
  assign periph_in.serial_receive_ch1  = rx3 ? pin_sync[3] : 1'b1;
  assign periph_in.dma_request_in_0    = dq2 ? pin_sync[2] : 1'b1;
  assign periph_in.dma_request_in_1    = dq5 ? pin_sync[5] : 1'b1;

endmodule // port_a_low_pin_function_select

`default_nettype wire

// File: bench/pin_sel_asserts.sv
// Purpose: Concurrent checks on the pin function select ports.
// Assumes: Straps stay steady around reset; the APB master keeps the protocol.
// Notes:   Write-driven checks look one cycle after the completing edge.
`timescale 1ns/1ps
`default_nettype none
module pin_sel_asserts
  import pin_mux_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         rst,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [11:0]  paddr,
  input wire logic [31:0]  pwdata,
  input wire logic         extended_mode,
  input wire logic         rom_disabled,
  input wire logic [15:0]  gpio_out,
  input wire logic [15:0]  gpio_oe,
  input wire periph_out_t  periph_out,
  input wire logic [15:0]  pin_out,
  input wire logic [15:0]  pin_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  sequence wr1_s;
    psel && penable && pwrite && paddr == sel1_offset;
  endsequence
  sequence wr2_s;
    psel && penable && pwrite && paddr == sel2_offset;
  endsequence
  chk_clk_route: assert property (wr1_s ##0 pwdata[14] |=> pin_oe[15] && pin_out[15] == periph_out.system_clk_output) else $error("pin 15 clock missing");
  chk_load_ext: assert property ($fell(rst) && extended_mode |-> ##3 (pin_oe[15] && pin_out[15] == periph_out.system_clk_output) [*2]) else $error("extended load wrong");
  chk_load_chip: assert property ($fell(rst) && !extended_mode |-> ##3 pin_out[15] == gpio_out[15]) else $error("single chip load wrong");
  chk_tx1_on: assert property (wr2_s ##0 pwdata[8] |=> pin_oe[4] && pin_out[4] == periph_out.serial_transmit_ch1) else $error("pin 4 transmit missing");
  chk_tx1_off: assert property (wr2_s ##0 !pwdata[8] |=> pin_oe[4] == gpio_oe[4] && pin_out[4] == gpio_out[4]) else $error("pin 4 not general");
  chk_rx1_input: assert property (wr2_s ##0 pwdata[6] |=> !pin_oe[3]) else $error("pin 3 still driven");
  chk_tx0_on: assert property (wr2_s ##0 pwdata[2] |=> pin_oe[1] && pin_out[1] == periph_out.serial_transmit_ch0) else $error("pin 1 transmit missing");
  chk_chip_gpio: assert property ((!extended_mode) [*3] |-> pin_out[10] == gpio_out[10] && pin_oe[10] == gpio_oe[10]) else $error("pin 10 bus in single chip");
  chk_rom_force: assert property ((extended_mode && rom_disabled) [*3] |-> pin_oe[14] && pin_out[14] == periph_out.read_strobe_n) else $error("read strobe not forced");
  chk_code_reserved: assert property (wr1_s ##0 pwdata[3:2] == 2'h3 |=> pin_oe[9] == gpio_oe[9]) else $error("pin 9 reserved code");
endmodule // pin_sel_asserts
bind port_a_low_pin_function_select pin_sel_asserts u_pin_sel_asserts (.clk_sys(clk_sys), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .extended_mode(extended_mode), .rom_disabled(rom_disabled), .gpio_out(gpio_out),
  .gpio_oe(gpio_oe), .periph_out(periph_out), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

// File: bench/port_a_low_pin_function_select_tb.sv
// Purpose: Register and pin routing tests for the pin function select block.
// Assumes: Peripheral outputs held low, port logic drives all ones, so routes differ.
// Notes:   Three power-on resets cover both modes and the disabled ROM case.
`timescale 1ns/1ps
`default_nettype none
module port_a_low_pin_function_select_tb;
  import pin_mux_pkg::*;
  logic        clk_sys = 1'h0;
  logic        rst = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic        extended_mode = 1'h1;
  logic        rom_disabled = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdata;
  logic        pready, pslverr, rerr;
  logic [15:0] pin_out, pin_oe, gpio_in;
  logic [1:0]  k;
  periph_in_t  pi;
  int          n_fail = 0;
  int          comparisons = 0;
  port_a_low_pin_function_select u_port_a_low_pin_function_select (.clk_sys(clk_sys),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extended_mode(extended_mode), .rom_disabled(rom_disabled), .gpio_out(16'hFFFF),
    .gpio_oe(16'hFFFF), .gpio_in(gpio_in), .periph_out(14'h0000), .periph_in(pi),
    .pin_in(16'h0200), .pin_out(pin_out), .pin_oe(pin_oe));
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // The slave may stretch the access phase; only the watchdog ends a wait.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    do @(posedge clk_sys); while (pready !== 1'h1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(negedge clk_sys);
  endtask
  task automatic por(input logic em, input logic rd);
    @(posedge clk_sys);
    rst <= 1'h1;
    extended_mode <= em;
    rom_disabled <= rd;
    repeat (16) @(posedge clk_sys);
    rst <= 1'h0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    end_of_test;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    por(1'h1, 1'h0);
    chk(gpio_in, 32'h0200);
    bus(1'h0, sel1_offset, 32'h0);
    chk(rdata, 32'h4000);
    bus(1'h0, sel2_offset, 32'h0);
    chk(rdata, 32'h0);
    bus(1'h1, sel1_offset, 32'hFFFFFFFF);
    bus(1'h0, sel1_offset, 32'h0);
    chk(rdata, 32'h555F);
    bus(1'h1, sel2_offset, 32'hFFFFFFFF);
    bus(1'h0, sel2_offset, 32'h0);
    chk(rdata, 32'hFD75);
    bus(1'h1, sel1_offset, 32'h5550);
    chk({pin_out[15:10], pin_oe[15:10]}, 32'h03F);
    $display("test registers and strobes done");
    for (int c = 0; c < 4; c++) begin
      k = c[1:0];
      bus(1'h1, sel1_offset, {28'h0, k, k});
      chk({pin_oe[9:8], pi.timer_ext_clock_d, pi.ext_interrupt_in_2},
          {{2{k == 2'h0 || k == 2'h3}}, k == 2'h1, k != 2'h2});
      bus(1'h1, sel2_offset, {16'h0, k, k, k, 4'h0, k, 4'h0});
      chk({pin_oe[7:5], pin_oe[2]}, {k != 2'h1, k != 2'h1, k == 2'h0, k == 2'h0});
      if (k != 2'h1) chk(pin_out[7:6], {2{k != 2'h2}});
      chk({pi.dma_request_in_1, pi.ext_interrupt_in_1, pi.dma_request_in_0,
           pi.ext_interrupt_in_0}, {k != 2'h2, k != 2'h3, k != 2'h2, k != 2'h3});
    end
    bus(1'h1, sel2_offset, 32'h0145);
    chk({pin_out[4], pin_oe[4:3], pin_out[1], pin_oe[1:0]}, 32'h12);
    chk({pi.serial_receive_ch1, pi.serial_receive_ch0}, 32'h0);
    $display("test field codes done");
    por(1'h0, 1'h0);
    bus(1'h0, sel1_offset, 32'h0);
    chk(rdata, 32'h0);
    bus(1'h1, sel1_offset, 32'h5550);
    chk(pin_out[15:10], 32'h1F);
    bus(1'h1, sel2_offset, 32'hA020);
    chk({pin_out[7:6], pin_oe[7:6], pin_oe[2]}, 32'h1F);
    $display("test single chip done");
    por(1'h1, 1'h1);
    chk({pin_out[14:10], pin_oe[14:10]}, 32'h01F);
    bus(1'h0, 12'h008, 32'h0);
    chk({rerr, rdata[15:0]}, 32'h10000);
    $display("test rom disabled done");
    end_of_test;
  end
endmodule // port_a_low_pin_function_select_tb
`default_nettype wire
